/* include/ccsr_pkg.sv */
package ccsr_pkg;
    // special function register addresses
    localparam logic [7:0] STACK_TOP_POINTER_ADDR = 8'h81;
    localparam logic [7:0] INDIRECT_POINTER_LOW_ADDR = 8'h82;
    localparam logic [7:0] INDIRECT_POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PROCESSOR_STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] ACCUMULATOR_ADDR = 8'hE0;
    localparam logic [7:0] SECOND_OPERAND_ADDR = 8'hF0;
    // reset values
    localparam logic [7:0] STACK_TOP_POINTER_RST = 8'h07;
    localparam logic [7:0] INDIRECT_POINTER_LOW_RST = 8'h00;
    localparam logic [7:0] INDIRECT_POINTER_HIGH_RST = 8'h00;
    localparam logic [7:0] PROCESSOR_STATUS_WORD_RST = 8'h00;
    localparam logic [7:0] ACCUMULATOR_RST = 8'h00;
    localparam logic [7:0] SECOND_OPERAND_RST = 8'h00;
    // status word bit positions
    localparam int CARRY_FLAG_BIT = 7;
    localparam int AUX_CARRY_FLAG_BIT = 6;
    localparam int USER_FLAG_ZERO_BIT = 5;
    localparam int BANK_SELECT_HIGH_BIT = 4;
    localparam int BANK_SELECT_LOW_BIT = 3;
    localparam int OVERFLOW_FLAG_BIT = 2;
    localparam int USER_FLAG_ONE_BIT = 1;
    localparam int PARITY_FLAG_BIT = 0;
    // largest product that fits one byte
    localparam logic [15:0] BYTE_MAX = 16'h00FF;
    // arithmetic operation codes
    typedef enum logic [3:0] {
        CCSR_OP_NONE = 4'h0,
        CCSR_OP_ADD = 4'h1,
        CCSR_OP_ADDC = 4'h2,
        CCSR_OP_SUBB = 4'h3,
        CCSR_OP_MUL = 4'h4,
        CCSR_OP_DIV = 4'h5,
        CCSR_OP_INC = 4'h6,
        CCSR_OP_DEC = 4'h7,
        CCSR_OP_DA = 4'h8
    } ccsr_op_e;
endpackage

/* logic/ccsr_alu.sv */
`timescale 1ns/1ps
module ccsr_alu (
    // operation and operands
    input wire ccsr_pkg::ccsr_op_e op,
    input wire logic [7:0] accum_in,
    input wire logic [7:0] opnd_in,
    input wire logic [7:0] second_in,
    input wire logic carry_in,
    // results
    output logic [7:0] accum_res,
    output logic [7:0] second_res,
    output logic wr_accum,
    output logic wr_second,
    output logic upd_carry,
    output logic carry_res,
    output logic upd_aux,
    output logic aux_res,
    output logic upd_ovf,
    output logic ovf_res
);
    import ccsr_pkg::*;

    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [15:0] prod;
    logic [7:0] oper;
    logic cin;

    always_comb begin
        accum_res = accum_in;
        second_res = second_in;
        wr_accum = 1'b0;
        wr_second = 1'b0;
        upd_carry = 1'b0;
        carry_res = 1'b0;
        upd_aux = 1'b0;
        aux_res = 1'b0;
        upd_ovf = 1'b0;
        ovf_res = 1'b0;
        cin = (op == CCSR_OP_ADDC || op == CCSR_OP_SUBB) ? carry_in : 1'b0;
        oper = (op == CCSR_OP_SUBB) ? ~opnd_in : opnd_in;
        sum9 = {1'b0, accum_in} + {1'b0, oper} + {8'h00, cin ^ (op == CCSR_OP_SUBB)};
        sum5 = {1'b0, accum_in[3:0]} + {1'b0, oper[3:0]} + {4'h0, cin ^ (op == CCSR_OP_SUBB)};
        prod = {8'h00, accum_in} * {8'h00, second_in};
        unique case (op)
            CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB: begin
                accum_res = sum9[7:0];
                wr_accum = 1'b1;
                upd_carry = 1'b1;
                upd_aux = 1'b1;
                upd_ovf = 1'b1;
                // borrow is the inverted carry of the complement sum
                carry_res = (op == CCSR_OP_SUBB) ? ~sum9[8] : sum9[8]; // [RULE5]
                aux_res = (op == CCSR_OP_SUBB) ? ~sum5[4] : sum5[4]; // [RULE6]
                ovf_res = (accum_in[7] == oper[7]) && (sum9[7] != accum_in[7]); // [RULE9]
            end
            CCSR_OP_MUL: begin
                accum_res = prod[7:0];
                second_res = prod[15:8];
                wr_accum = 1'b1;
                wr_second = 1'b1;
                upd_carry = 1'b1;
                upd_ovf = 1'b1;
                ovf_res = prod > BYTE_MAX; // [RULE10] [RULE12]
            end
            CCSR_OP_DIV: begin
                wr_accum = 1'b1;
                wr_second = 1'b1;
                upd_carry = 1'b1;
                upd_ovf = 1'b1;
                if (second_in == 8'h00) begin
                    ovf_res = 1'b1; // [RULE11]
                end else begin
                    accum_res = accum_in / second_in;
                    second_res = accum_in % second_in; // [RULE12]
                end
            end
            default: begin
            end
        endcase
    end
endmodule

/* logic/ccsr_core_regs.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] stack pointer increments before push stores
// [RULE2] stack pointer resets to 0x07
// [RULE3] 16-bit pointer split into two bytes
// [RULE4] full pointer addresses external ram and flash
// [RULE5] carry set on carry or borrow
// [RULE6] aux carry tracks nibble carry or borrow
// [RULE7] user flags bits 5, 1 software only
// [RULE8] bank select maps register bank address
// [RULE9] overflow set on signed add/subtract overflow
// [RULE10] overflow set when product exceeds 255
// [RULE11] overflow set on divide by zero
// [RULE12] those instructions clear overflow otherwise
// [RULE13] parity bit follows accumulator odd parity
// [RULE14] accumulator at 0xE0, resets to zero
// [RULE15] second operand at 0xF0, resets zero
// [RULE16] status word at 0xD0, resets zero
// [RULE17] software leaves reserved bits at zero
// [RULE18] stack pointer decrements after pop reads
module ccsr_core_regs (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // execution unit
    input wire ccsr_pkg::ccsr_op_e alu_op,
    input wire logic [7:0] alu_operand,
    input wire logic push,
    input wire logic pop,
    input wire logic carry_wr,
    input wire logic carry_val,
    input wire logic ptr_inc,
    // derived addresses and state
    output logic [7:0] stack_addr,
    output logic [15:0] indirect_pointer,
    output logic [4:0] bank_base,
    output logic [7:0] accumulator,
    output logic [7:0] second_operand,
    output logic [7:0] processor_status_word
);
    import ccsr_pkg::*;

    logic [7:0] stack_top_pointer_ff;
    logic [7:0] indirect_pointer_low_ff;
    logic [7:0] indirect_pointer_high_ff;
    logic [7:0] status_word_ff;
    logic [7:0] accumulator_ff;
    logic [7:0] second_operand_ff;
    logic [7:0] nxt_status_word;
    logic [7:0] nxt_accumulator;
    logic [7:0] nxt_second_operand;
    logic [7:0] bit_merge;
    logic [7:0] accum_res;
    logic [7:0] second_res;
    logic wr_accum;
    logic wr_second;
    logic upd_carry;
    logic carry_res;
    logic upd_aux;
    logic aux_res;
    logic upd_ovf;
    logic ovf_res;
    logic [7:0] cur_byte;
    logic [15:0] nxt_ptr;

    //////////////////////////////////////////////////////////////////////////
    // arithmetic unit
    ccsr_alu u_alu (
        .op(alu_op),
        .accum_in(accumulator_ff),
        .opnd_in(alu_operand),
        .second_in(second_operand_ff),
        .carry_in(status_word_ff[CARRY_FLAG_BIT]),
        .accum_res(accum_res),
        .second_res(second_res),
        .wr_accum(wr_accum),
        .wr_second(wr_second),
        .upd_carry(upd_carry),
        .carry_res(carry_res),
        .upd_aux(upd_aux),
        .aux_res(aux_res),
        .upd_ovf(upd_ovf),
        .ovf_res(ovf_res)
    );

    //////////////////////////////////////////////////////////////////////////
    // bit-addressed write merge
    always_comb begin
        unique case (sfr_addr)
            STACK_TOP_POINTER_ADDR: cur_byte = stack_top_pointer_ff;
            INDIRECT_POINTER_LOW_ADDR: cur_byte = indirect_pointer_low_ff;
            INDIRECT_POINTER_HIGH_ADDR: cur_byte = indirect_pointer_high_ff;
            PROCESSOR_STATUS_WORD_ADDR: cur_byte = status_word_ff;
            ACCUMULATOR_ADDR: cur_byte = accumulator_ff;
            SECOND_OPERAND_ADDR: cur_byte = second_operand_ff;
            default: cur_byte = 8'h00;
        endcase
        bit_merge = cur_byte;
        bit_merge[sfr_bit_sel] = sfr_bit_val;
    end

    //////////////////////////////////////////////////////////////////////////
    // accumulator and second operand
    always_comb begin
        nxt_accumulator = accumulator_ff;
        if (wr_accum) begin
            nxt_accumulator = accum_res;
        end
        if (sfr_addr == ACCUMULATOR_ADDR && sfr_wr) begin
            nxt_accumulator = sfr_wdata; // [RULE14]
        end else if (sfr_addr == ACCUMULATOR_ADDR && sfr_bit_wr) begin
            nxt_accumulator = bit_merge;
        end
    end

    always_comb begin
        nxt_second_operand = second_operand_ff;
        if (wr_second) begin
            nxt_second_operand = second_res;
        end
        if (sfr_addr == SECOND_OPERAND_ADDR && sfr_wr) begin
            nxt_second_operand = sfr_wdata; // [RULE15]
        end else if (sfr_addr == SECOND_OPERAND_ADDR && sfr_bit_wr) begin
            nxt_second_operand = bit_merge;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            accumulator_ff <= ACCUMULATOR_RST; // [RULE14]
            second_operand_ff <= SECOND_OPERAND_RST; // [RULE15]
        end else begin
            accumulator_ff <= nxt_accumulator;
            second_operand_ff <= nxt_second_operand;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status word
    always_comb begin
        nxt_status_word = status_word_ff;
        if (sfr_addr == PROCESSOR_STATUS_WORD_ADDR && sfr_wr) begin
            nxt_status_word = sfr_wdata; // [RULE16]
        end else if (sfr_addr == PROCESSOR_STATUS_WORD_ADDR && sfr_bit_wr) begin
            nxt_status_word = bit_merge; // [RULE7]
        end
        // hardware flag updates win over a software write in the same cycle
        if (carry_wr) begin
            nxt_status_word[CARRY_FLAG_BIT] = carry_val;
        end
        if (upd_carry) begin
            nxt_status_word[CARRY_FLAG_BIT] = carry_res; // [RULE5]
        end
        if (upd_aux) begin
            nxt_status_word[AUX_CARRY_FLAG_BIT] = aux_res; // [RULE6]
        end
        if (upd_ovf) begin
            nxt_status_word[OVERFLOW_FLAG_BIT] = ovf_res; // [RULE9] [RULE12]
        end
        // parity is recomputed, never stored from software
        nxt_status_word[PARITY_FLAG_BIT] = ^nxt_accumulator; // [RULE13]
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_word_ff <= PROCESSOR_STATUS_WORD_RST; // [RULE16]
        end else begin
            status_word_ff <= nxt_status_word;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // stack top pointer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stack_top_pointer_ff <= STACK_TOP_POINTER_RST; // [RULE2]
        end else if (sfr_addr == STACK_TOP_POINTER_ADDR && sfr_wr) begin
            stack_top_pointer_ff <= sfr_wdata;
        end else if (sfr_addr == STACK_TOP_POINTER_ADDR && sfr_bit_wr) begin
            stack_top_pointer_ff <= bit_merge;
        end else if (push) begin
            stack_top_pointer_ff <= stack_top_pointer_ff + 8'h01; // [RULE1]
        end else if (pop) begin
            stack_top_pointer_ff <= stack_top_pointer_ff - 8'h01; // [RULE18]
        end
    end

    // push stores at the incremented slot, pop reads the current one
    assign stack_addr = push ? stack_top_pointer_ff + 8'h01 : stack_top_pointer_ff; // [RULE1]

    //////////////////////////////////////////////////////////////////////////
    // indirect pointer
    assign nxt_ptr = {indirect_pointer_high_ff, indirect_pointer_low_ff} + 16'h0001;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            indirect_pointer_low_ff <= INDIRECT_POINTER_LOW_RST;
        end else if (sfr_addr == INDIRECT_POINTER_LOW_ADDR && sfr_wr) begin
            indirect_pointer_low_ff <= sfr_wdata; // [RULE3]
        end else if (sfr_addr == INDIRECT_POINTER_LOW_ADDR && sfr_bit_wr) begin
            indirect_pointer_low_ff <= bit_merge;
        end else if (ptr_inc) begin
            indirect_pointer_low_ff <= nxt_ptr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            indirect_pointer_high_ff <= INDIRECT_POINTER_HIGH_RST; // [RULE3]
        end else if (sfr_addr == INDIRECT_POINTER_HIGH_ADDR && sfr_wr) begin
            indirect_pointer_high_ff <= sfr_wdata; // [RULE3]
        end else if (sfr_addr == INDIRECT_POINTER_HIGH_ADDR && sfr_bit_wr) begin
            indirect_pointer_high_ff <= bit_merge;
        end else if (ptr_inc) begin
            indirect_pointer_high_ff <= nxt_ptr[15:8];
        end
    end

    assign indirect_pointer = {indirect_pointer_high_ff, indirect_pointer_low_ff}; // [RULE4]

    //////////////////////////////////////////////////////////////////////////
    // bank select and read path
    assign bank_base = {status_word_ff[BANK_SELECT_HIGH_BIT:BANK_SELECT_LOW_BIT], 3'h0}; // [RULE8]

    always_comb begin
        sfr_hit = 1'b1;
        unique case (sfr_addr)
            STACK_TOP_POINTER_ADDR: sfr_rdata = stack_top_pointer_ff;
            INDIRECT_POINTER_LOW_ADDR: sfr_rdata = indirect_pointer_low_ff;
            INDIRECT_POINTER_HIGH_ADDR: sfr_rdata = indirect_pointer_high_ff;
            PROCESSOR_STATUS_WORD_ADDR: sfr_rdata = status_word_ff;
            ACCUMULATOR_ADDR: sfr_rdata = accumulator_ff;
            SECOND_OPERAND_ADDR: sfr_rdata = second_operand_ff;
            default: begin
                sfr_rdata = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
    end

    assign accumulator = accumulator_ff;
    assign second_operand = second_operand_ff;
    assign processor_status_word = status_word_ff;
endmodule

/* verification/ccsr_core_regs_test.sv */
`timescale 1ns/1ps
module ccsr_core_regs_test;
    import ccsr_pkg::*;
    typedef struct packed {
        ccsr_op_e op;
        logic [7:0] a1, o1, s1, f1, a2, s2, f2, m;
    } ccsr_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [7:0] sfr_rdata, stack_addr, accumulator, second_operand, processor_status_word;
    logic [7:0] alu_operand;
    logic sfr_hit, push, pop, carry_wr, carry_val, ptr_inc;
    logic [15:0] indirect_pointer;
    logic [4:0] bank_base;
    ccsr_op_e alu_op;
    int num_errors = 0, comparisons = 0;
    ccsr_row_s rows [9] = '{
        '{CCSR_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h44, 8'hC4},
        '{CCSR_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hC4},
        '{CCSR_OP_ADDC, 8'h0F, 8'h00, 8'h00, 8'h80, 8'h10, 8'h00, 8'h40, 8'hC4},
        '{CCSR_OP_SUBB, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hC0, 8'hC4},
        '{CCSR_OP_SUBB, 8'h80, 8'h01, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h44, 8'hC4},
        '{CCSR_OP_MUL, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00, 8'h01, 8'h04, 8'h84},
        '{CCSR_OP_MUL, 8'h0F, 8'h00, 8'h11, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h84},
        '{CCSR_OP_DIV, 8'h07, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04, 8'h84},
        '{CCSR_OP_DIV, 8'h07, 8'h00, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h84}
    };
    always #12.5 clk = ~clk;
    ccsr_exec_model u_exec (.clk, .alu_op, .alu_operand, .push, .pop, .carry_wr, .carry_val,
        .ptr_inc);
    ccsr_core_regs DUT (.clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel,
        .sfr_bit_val, .sfr_rdata, .sfr_hit, .alu_op, .alu_operand, .push, .pop, .carry_wr,
        .carry_val, .ptr_inc, .stack_addr, .indirect_pointer, .bank_base, .accumulator,
        .second_operand, .processor_status_word);
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic bw, input logic [2:0] k);
        @(posedge clk);
        #1;
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_bit_sel = k;
        sfr_bit_val = d[0];
        {sfr_wr, sfr_bit_wr} = {!bw, bw};
        @(posedge clk);
        #1;
        {sfr_wr, sfr_bit_wr} = 2'b00;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e, input string n);
        @(posedge clk);
        #1;
        sfr_addr = ad;
        #1;
        chk(n, 16'(e), 16'(sfr_rdata));
    endtask
    task automatic reset_chk;
        logic [7:0] ad [6];
        ad = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
        for (int i = 0; i < 6; i++) begin
            rd(ad[i], (i == 0) ? 8'h07 : 8'h00, "reset value");
            chk("mapped hit", 16'h0001, 16'(sfr_hit));
        end
        rd(8'h84, 8'h00, "unmapped read");
        chk("unmapped hit", 16'h0000, 16'(sfr_hit));
        $display("test reset done");
    endtask
    task automatic results;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #50us;
        num_errors++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        reset_chk();
        foreach (rows[i]) begin
            wr(8'hE0, rows[i].a1, 1'b0, 3'h0);
            wr(8'hF0, rows[i].s1, 1'b0, 3'h0);
            wr(8'hD0, rows[i].f1, 1'b0, 3'h0);
            u_exec.issue(rows[i].op, rows[i].o1, 4'h0);
            u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h0);
            #1;
            chk("accumulator", 16'(rows[i].a2), 16'(accumulator));
            chk("second", 16'(rows[i].s2), 16'(second_operand));
            chk("flags", 16'(rows[i].f2), 16'(processor_status_word & rows[i].m));
            chk("parity", 16'(^rows[i].a2), 16'(processor_status_word[0]));
        end
        $display("test arithmetic done");
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h8);
        #1;
        chk("push address", 16'h0008, 16'(stack_addr));
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h8);
        #1;
        chk("push address", 16'h0009, 16'(stack_addr));
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h4);
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h0);
        rd(8'h81, 8'h08, "stack after pop");
        $display("test stack done");
        wr(8'h83, 8'h12, 1'b0, 3'h0);
        wr(8'h82, 8'hFF, 1'b0, 3'h0);
        rd(8'h83, 8'h12, "pointer high");
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h2);
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h0);
        #1;
        chk("pointer", 16'h1300, indirect_pointer);
        $display("test pointer done");
        for (int k = 0; k < 4; k++) begin
            wr(8'hD0, 8'(k << 3), 1'b0, 3'h0);
            @(posedge clk);
            #1;
            chk("bank base", 16'(k * 8), 16'(bank_base));
        end
        $display("test bank done");
        wr(8'hD0, 8'h01, 1'b1, 3'h5);
        wr(8'hD0, 8'h01, 1'b1, 3'h1);
        wr(8'hE0, 8'h7F, 1'b0, 3'h0);
        u_exec.issue(CCSR_OP_ADD, 8'h01, 4'h0);
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h0);
        #1;
        chk("user flags", 16'h0022, 16'(processor_status_word & 8'h22));
        wr(8'hE0, 8'h01, 1'b1, 3'h0);
        rd(8'hE0, 8'h81, "accumulator bit");
        chk("parity", 16'h0000, 16'(processor_status_word[0]));
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h1);
        u_exec.issue(CCSR_OP_NONE, 8'h00, 4'h0);
        #1;
        chk("carry write", 16'h00A2, 16'(processor_status_word & 8'hA2));
        $display("test bit access done");
        @(posedge clk);
        #1;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        reset_chk();
        results();
    end
endmodule

/* verification/ccsr_exec_model.sv */
`timescale 1ns/1ps
module ccsr_exec_model
    import ccsr_pkg::*;
(
    // clock
    input wire logic clk,
    // execution requests
    output ccsr_pkg::ccsr_op_e alu_op,
    output logic [7:0] alu_operand,
    output logic push,
    output logic pop,
    output logic carry_wr,
    output logic carry_val,
    output logic ptr_inc
);
    initial begin
        alu_op = CCSR_OP_NONE;
        alu_operand = 8'h00;
        {push, pop, ptr_inc, carry_wr, carry_val} = 5'h00;
    end
    // one request per cycle, launched just after the edge; ctl is push, pop, inc, carry
    task automatic issue(input ccsr_op_e op, input logic [7:0] opnd, input logic [3:0] ctl);
        @(posedge clk);
        #1;
        alu_op = op;
        alu_operand = opnd;
        {push, pop, ptr_inc, carry_wr} = ctl;
        carry_val = ctl[0];
    endtask
endmodule

/* verification/ccsr_monitor.sv */
`timescale 1ns/1ps
module ccsr_monitor
    import ccsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register access and execution requests
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire ccsr_pkg::ccsr_op_e alu_op,
    input wire logic [7:0] alu_operand,
    input wire logic push,
    input wire logic pop,
    // state
    input wire logic [7:0] stack_addr,
    input wire logic [15:0] indirect_pointer,
    input wire logic [4:0] bank_base,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] second_operand,
    input wire logic [7:0] processor_status_word
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire stk_wr = (sfr_wr || sfr_bit_wr) && sfr_addr == STACK_TOP_POINTER_ADDR;
    wire [8:0] sum9 = {1'b0, accumulator} + {1'b0, alu_operand};
    wire [4:0] nib5 = {1'b0, accumulator[3:0]} + {1'b0, alu_operand[3:0]};
    wire sgn_flip = accumulator[7] == alu_operand[7] && sum9[7] != accumulator[7];
    wire [15:0] prod = {8'h00, accumulator} * {8'h00, second_operand};
    //////////////////////////////////////////////////////////////////////////////
    stack_reset_a: assert property (
        $rose(nrst) && !push |-> stack_addr == 8'h07 && processor_status_word == 8'h00)
        else $error("state not at reset value after release");
    push_step_a: assert property (
        push && !stk_wr ##1 !push |-> stack_addr == $past(stack_addr))
        else $error("push did not store at pre-incremented address");
    pop_step_a: assert property (
        pop && !push && !stk_wr ##1 !push |-> stack_addr == $past(stack_addr) - 8'h01)
        else $error("pop did not decrement the stack pointer");
    ptr_write_a: assert property (
        sfr_wr && sfr_addr == 8'h83 |=> indirect_pointer[15:8] == $past(sfr_wdata))
        else $error("pointer high byte write lost");
    bank_map_a: assert property (
        $stable(processor_status_word[4:3]) |-> bank_base == {processor_status_word[4:3], 3'h0})
        else $error("bank base does not follow bank select");
    parity_flag_a: assert property (
        processor_status_word[0] == ^accumulator)
        else $error("parity flag wrong");
    user_flag_hold_a: assert property (
        !((sfr_wr || sfr_bit_wr) && sfr_addr == PROCESSOR_STATUS_WORD_ADDR)
        |=> $stable({processor_status_word[5], processor_status_word[1]}))
        else $error("hardware changed a user flag");
    add_flags_a: assert property (
        alu_op == CCSR_OP_ADD |=> processor_status_word[7:6] == $past({sum9[8], nib5[4]})
        && processor_status_word[2] == $past(sgn_flip)) else $error("add flags wrong");
    mul_flag_a: assert property (
        alu_op == CCSR_OP_MUL |=> processor_status_word[2] == $past(prod > 16'h00FF)
        && !processor_status_word[7]) else $error("multiply flags wrong");
    div_zero_a: assert property (
        alu_op == CCSR_OP_DIV && second_operand == 8'h00 |=> processor_status_word[2])
        else $error("divide by zero not flagged");
    cover property (push ##1 pop);
    cover property (alu_op == CCSR_OP_MUL ##1 processor_status_word[2]);
    cover property (alu_op == CCSR_OP_DIV && second_operand == 8'h00);
endmodule
bind ccsr_core_regs ccsr_monitor u_mon (.clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_bit_wr, .alu_op, .alu_operand, .push, .pop, .stack_addr, .indirect_pointer,
    .bank_base, .accumulator, .second_operand, .processor_status_word);
